// [tpw_map.svh]
// Register offsets, field positions, reset values and widths of the three-phase PWM timing block.
// Assumes inclusion by bare name from the block's package and modules.
`ifndef TPW_MAP_SVH
`define TPW_MAP_SVH

`define TPW_ADDR_W          8
`define TPW_DATA_W          32
`define TPW_ADDR_CONTROL    8'h00
`define TPW_ADDR_STATUS     8'h04
`define TPW_ADDR_HALF       8'h08
`define TPW_ADDR_DEAD       8'h0c
`define TPW_ADDR_DUTY_A     8'h10
`define TPW_ADDR_DUTY_B     8'h14
`define TPW_ADDR_DUTY_C     8'h18
`define TPW_ADDR_OES        8'h1c

`define TPW_CNT_W           16
`define TPW_DEAD_W          10
`define TPW_OES_W           9
`define TPW_CTL_W           16
`define TPW_CHOP_W          8

`define TPW_CTL_DOUBLE      2
`define TPW_CTL_EXTSYNC     3
`define TPW_CTL_CHOP_HI     4
`define TPW_CTL_CHOP_LO     5
`define TPW_CTL_DIV_LSB     8
`define TPW_CTL_DIV_MSB     15

`define TPW_STA_HALF        0
`define TPW_STA_TRIP        1
`define TPW_STA_ARMED       2

`define TPW_OES_HI_BIT(p)   (5 - 2 * (p))
`define TPW_OES_LO_BIT(p)   (4 - 2 * (p))
`define TPW_OES_XOVER(p)    (8 - (p))

`define TPW_RST_CONTROL     16'h0000
`define TPW_RST_HALF        16'h0000
`define TPW_RST_DEAD        10'h000
`define TPW_RST_DUTY        16'h0000
`define TPW_RST_OES         9'h000
`define TPW_PHASES          3

`endif

// [tpw_pkg.sv]
// Types shared by the three-phase PWM timing block.
// Assumes the constants header is available by bare name.
`include "tpw_map.svh"

package tpw_pkg;

  typedef enum logic [1:0] {
    TPW_IDLE,
    TPW_FIRST_HALF,
    TPW_SECOND_HALF
  } tpw_state_t;

  typedef logic [`TPW_CNT_W-1:0]  tpw_count_t;
  typedef logic [`TPW_DEAD_W-1:0] tpw_dead_t;

endpackage : tpw_pkg

// [tpw_phase.sv]
// One inverter leg: duty compare with dead time, crossover, output disable and chopping.
// Assumes a centre-distance count from the period counter, synchronous to pclk.
`timescale 1ns/1ps
`include "tpw_map.svh"

module tpw_phase
  import tpw_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire tpw_count_t center_dist,
  input  wire tpw_count_t duty,
  input  wire tpw_dead_t  dead,
  input  wire logic       crossover,
  input  wire logic       disable_hi,
  input  wire logic       disable_lo,
  input  wire logic       chop,
  input  wire logic       chop_hi_en,
  input  wire logic       chop_lo_en,
  output logic            high_out,
  output logic            low_out
);

  logic [`TPW_CNT_W:0] dist_plus_dead;
  logic [`TPW_CNT_W:0] duty_plus_dead;
  logic                raw_hi;
  logic                raw_lo;
  logic                steer_hi;
  logic                steer_lo;
  logic                next_hi;
  logic                next_lo;

  // Both switching edges move away from the compare point by the dead time.
  assign dist_plus_dead = {1'b0, center_dist} + {7'h00, dead};
  assign duty_plus_dead = {1'b0, duty} + {7'h00, dead};
  assign raw_hi = run && (dist_plus_dead < {1'b0, duty});
  assign raw_lo = run && ({1'b0, center_dist} >= duty_plus_dead);
  assign steer_hi = crossover ? raw_lo : raw_hi;
  assign steer_lo = crossover ? raw_hi : raw_lo;
  assign next_hi = steer_hi && !disable_hi && (!chop_hi_en || chop);
  assign next_lo = steer_lo && !disable_lo && (!chop_lo_en || chop);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_out <= 1'b0;
      low_out  <= 1'b0;
    end else begin
      high_out <= next_hi;
      low_out  <= next_lo;
    end
  end

endmodule : tpw_phase

// [tpw_top.sv]
// Three-phase centre-aligned PWM timing block with APB register access.
// Assumes an APB master on pclk, an active-low trip pin and an external sync pin synchronous to pclk.
`timescale 1ns/1ps
`include "tpw_map.svh"

// Notes on behaviour
// - Three complementary centre-aligned dead-time-adjusted pairs.
// - Make sync pulse; optionally use external sync.
// - Steer each channel, enable six outputs individually.
// - Mix chopping signal into outputs when enabled.
// - Trip pin shuts down and resets timing.
// - Core clock; sync and shutdown interrupts.
// - Half-period value counts clocks per half.
// - Half-period register is 16 bits wide.
// - One dead time, twice value in clocks.
// - Dead time up to 0x3ff, two-clock steps.
// - Zero dead time inserts no delay.
// - Control bit 2 selects double update; single default.
// - Single mode: sync starts period, latches values.
// - Enable and steer latched on sync edges.
// - Double mode: mid-period sync latches again.
// - Status bit 0 shows second half.
// - Duty registers hold high-side half-period on time.
// - Outputs active high.
// - Trip low forces outputs off, unclocked.
// - No toggling until period and duties written.
// - Bits 0-5 disable outputs; 8,7,6 swap pairs.
module tpw_top
  import tpw_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`TPW_ADDR_W-1:0] paddr,
  input  wire logic [`TPW_DATA_W-1:0] pwdata,
  output logic      [`TPW_DATA_W-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   shutdown_trip_pin_n,
  input  wire logic                   ext_sync_in,
  output logic                        period_sync_pulse,
  output logic                        sync_irq,
  output logic                        shutdown_irq,
  output logic                        phase_a_high_out,
  output logic                        phase_a_low_out,
  output logic                        phase_b_high_out,
  output logic                        phase_b_low_out,
  output logic                        phase_c_high_out,
  output logic                        phase_c_low_out
);

  logic [`TPW_CTL_W-1:0]  modulator_control;
  tpw_count_t             half_period_count;
  tpw_dead_t              dead_time_count;
  tpw_count_t             duty_shadow [`TPW_PHASES];
  logic [`TPW_OES_W-1:0]  output_enable_steer;
  logic [3:0]             written;
  tpw_count_t             act_half;
  tpw_dead_t              act_dead;
  tpw_count_t             act_duty [`TPW_PHASES];
  logic [`TPW_OES_W-1:0]  act_oes;
  tpw_state_t             state;
  tpw_count_t             cnt;
  logic                   trip_meta;
  logic                   trip_sync;
  logic                   trip_prev;
  logic                   ext_prev;
  logic [`TPW_CHOP_W-1:0] chop_cnt;
  logic                   chop;
  logic                   wr_en;
  logic                   setup;
  logic                   armed;
  logic                   tripped;
  logic                   ext_mode;
  logic                   double_mode;
  logic                   ext_rise;
  logic                   end_of_period;
  logic                   mid_point;
  logic                   period_start;
  logic                   mid_sync;
  logic                   latch_now;
  logic [`TPW_PHASES-1:0] hi_q;
  logic [`TPW_PHASES-1:0] lo_q;
  logic [`TPW_DATA_W:0]   rd_word;

  // Returns the register word at an address, or flags it as unmapped.
  function automatic logic [`TPW_DATA_W:0] read_word(input logic [`TPW_ADDR_W-1:0] a);
    logic [`TPW_DATA_W:0] r;
    r = '0;
    unique case (a)
      `TPW_ADDR_CONTROL: r[`TPW_CTL_W-1:0] = modulator_control;
      `TPW_ADDR_STATUS: begin
        r[`TPW_STA_HALF]  = (state == TPW_SECOND_HALF);
        r[`TPW_STA_TRIP]  = trip_sync;
        r[`TPW_STA_ARMED] = armed;
      end
      `TPW_ADDR_HALF:   r[`TPW_CNT_W-1:0] = half_period_count;
      `TPW_ADDR_DEAD:   r[`TPW_DEAD_W-1:0] = dead_time_count;
      `TPW_ADDR_DUTY_A: r[`TPW_CNT_W-1:0] = duty_shadow[0];
      `TPW_ADDR_DUTY_B: r[`TPW_CNT_W-1:0] = duty_shadow[1];
      `TPW_ADDR_DUTY_C: r[`TPW_CNT_W-1:0] = duty_shadow[2];
      `TPW_ADDR_OES:    r[`TPW_OES_W-1:0] = output_enable_steer;
      default:          r[`TPW_DATA_W] = 1'b1;
    endcase
    return r;
  endfunction : read_word

  // Returns the bus address of one phase's duty register.
  function automatic logic [`TPW_ADDR_W-1:0] duty_addr(input int p);
    logic [`TPW_ADDR_W-1:0] a;
    unique case (p)
      0:       a = `TPW_ADDR_DUTY_A;
      1:       a = `TPW_ADDR_DUTY_B;
      default: a = `TPW_ADDR_DUTY_C;
    endcase
    return a;
  endfunction : duty_addr

  // Read-side decode of the current address.
  always_comb begin
    rd_word = read_word(paddr);
  end

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign armed = &written;
  assign tripped = !trip_sync;
  assign ext_mode = modulator_control[`TPW_CTL_EXTSYNC];
  assign double_mode = modulator_control[`TPW_CTL_DOUBLE];
  assign ext_rise = ext_sync_in && !ext_prev;
  assign end_of_period = (state == TPW_SECOND_HALF) && (cnt >= act_half - 16'h0001);
  assign mid_point = (state == TPW_FIRST_HALF) && (cnt == '0);
  // The period starts on the internal wrap, or on the external pin when it is selected.
  assign period_start = armed && !tripped &&
                        (ext_mode ? (ext_rise && state != TPW_FIRST_HALF)
                                  : (end_of_period || state == TPW_IDLE));
  assign mid_sync = mid_point && double_mode;
  assign latch_now = period_start || mid_sync;

  // APB slave: the answer comes in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      if (setup) begin
        pslverr <= rd_word[`TPW_DATA_W];
        prdata  <= pwrite ? '0 : rd_word[`TPW_DATA_W-1:0];
      end else begin
        pslverr <= 1'b0;
        prdata  <= '0;
      end
    end
  end

  // Software-visible shadow registers, one process per register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modulator_control <= `TPW_RST_CONTROL;
    end else if (wr_en && paddr == `TPW_ADDR_CONTROL) begin
      modulator_control <= pwdata[`TPW_CTL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_period_count <= `TPW_RST_HALF;
    end else if (wr_en && paddr == `TPW_ADDR_HALF) begin
      half_period_count <= pwdata[`TPW_CNT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dead_time_count <= `TPW_RST_DEAD;
    end else if (wr_en && paddr == `TPW_ADDR_DEAD) begin
      dead_time_count <= pwdata[`TPW_DEAD_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_enable_steer <= `TPW_RST_OES;
    end else if (wr_en && paddr == `TPW_ADDR_OES) begin
      output_enable_steer <= pwdata[`TPW_OES_W-1:0];
    end
  end

  // One duty shadow per phase.
  for (genvar p = 0; p < `TPW_PHASES; p++) begin : g_duty
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        duty_shadow[p] <= `TPW_RST_DUTY;
      end else if (wr_en && paddr == duty_addr(p)) begin
        duty_shadow[p] <= pwdata[`TPW_CNT_W-1:0];
      end
    end
  end

  // Remembers which of the registers that arm the timer have been written since reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      written <= '0;
    end else if (wr_en) begin
      written[0] <= written[0] || (paddr == `TPW_ADDR_HALF);
      for (int p = 0; p < `TPW_PHASES; p++) begin
        written[p + 1] <= written[p + 1] || (paddr == duty_addr(p));
      end
    end
  end

  // Active copies used by the timing unit change only on the latching sync edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_half <= `TPW_RST_HALF;
      act_dead <= `TPW_RST_DEAD;
      act_duty <= '{default: `TPW_RST_DUTY};
      act_oes  <= `TPW_RST_OES;
    end else if (latch_now) begin
      act_half <= half_period_count;
      act_dead <= dead_time_count;
      act_duty <= duty_shadow;
      act_oes  <= output_enable_steer;
    end
  end

  // Trip pin synchroniser and its edge history.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_meta <= 1'b1;
      trip_sync <= 1'b1;
      trip_prev <= 1'b1;
    end else begin
      trip_meta <= shutdown_trip_pin_n;
      trip_sync <= trip_meta;
      trip_prev <= trip_sync;
    end
  end

  // External sync pin history for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_sync_in;
    end
  end

  // Up/down period counter: counts down to the centre, then back up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= TPW_IDLE;
      cnt   <= '0;
    end else if (tripped || !armed) begin
      state <= TPW_IDLE;
      cnt   <= '0;
    end else if (period_start) begin
      state <= TPW_FIRST_HALF;
      cnt   <= half_period_count - 16'h0001;
    end else begin
      unique case (state)
        TPW_IDLE: cnt <= '0;
        TPW_FIRST_HALF: begin
          if (mid_point) begin
            state <= TPW_SECOND_HALF;
          end else begin
            cnt <= cnt - 16'h0001;
          end
        end
        TPW_SECOND_HALF: begin
          if (!end_of_period) begin
            cnt <= cnt + 16'h0001;
          end
        end
      endcase
    end
  end

  // Sync pulse toward the pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_sync_pulse <= 1'b0;
    end else begin
      period_sync_pulse <= latch_now;
    end
  end

  // Interrupt on every latching sync event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_irq <= 1'b0;
    end else begin
      sync_irq <= latch_now;
    end
  end

  // Interrupt on the synced falling edge of the trip pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown_irq <= 1'b0;
    end else begin
      shutdown_irq <= trip_prev && !trip_sync;
    end
  end

  // Chopping carrier divided from the core clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_cnt <= '0;
      chop     <= 1'b0;
    end else if (chop_cnt >= modulator_control[`TPW_CTL_DIV_MSB:`TPW_CTL_DIV_LSB]) begin
      chop_cnt <= '0;
      chop     <= !chop;
    end else begin
      chop_cnt <= chop_cnt + 8'h01;
    end
  end

  // One leg per phase.
  for (genvar p = 0; p < `TPW_PHASES; p++) begin : g_leg
    tpw_phase u_leg (
      .pclk        (pclk),
      .presetn     (presetn),
      .run         (state != TPW_IDLE),
      .center_dist (cnt),
      .duty        (act_duty[p]),
      .dead        (act_dead),
      .crossover   (act_oes[`TPW_OES_XOVER(p)]),
      .disable_hi  (act_oes[`TPW_OES_HI_BIT(p)]),
      .disable_lo  (act_oes[`TPW_OES_LO_BIT(p)]),
      .chop        (chop),
      .chop_hi_en  (modulator_control[`TPW_CTL_CHOP_HI]),
      .chop_lo_en  (modulator_control[`TPW_CTL_CHOP_LO]),
      .high_out    (hi_q[p]),
      .low_out     (lo_q[p])
    );
  end

  // The trip pin gates the registered outputs directly so loss of clock cannot hold them on.
  assign phase_a_high_out = hi_q[0] && shutdown_trip_pin_n;
  assign phase_a_low_out  = lo_q[0] && shutdown_trip_pin_n;
  assign phase_b_high_out = hi_q[1] && shutdown_trip_pin_n;
  assign phase_b_low_out  = lo_q[1] && shutdown_trip_pin_n;
  assign phase_c_high_out = hi_q[2] && shutdown_trip_pin_n;
  assign phase_c_low_out  = lo_q[2] && shutdown_trip_pin_n;

endmodule : tpw_top

// [tpw_gate_model.sv]
// Gate driver model for the three inverter legs: counts cycles with both switches of a leg on.
// Assumes the six active-high gate commands of the PWM block, high side above low side.
`timescale 1ns/1ps

module tpw_gate_model (
  input  wire logic       pclk,
  input  wire logic [5:0] gate,
  output int              shoot_count
);
  initial shoot_count = 0;

  // A leg with both switches on shorts the supply, so it is counted as a fault.
  always @(posedge pclk) begin
    for (int p = 0; p < 3; p++) begin
      if (gate[2*p+1] === 1'b1 && gate[2*p] === 1'b1) begin
        shoot_count <= shoot_count + 1;
      end
    end
  end
endmodule : tpw_gate_model

// [tpw_top_properties.sv]
// Protocol and output checks on the ports of the three-phase PWM block.
// Assumes one clock pclk and the active-low asynchronous reset presetn.
`timescale 1ns/1ps

module tpw_top_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        shutdown_trip_pin_n,
  input wire logic        ext_sync_in,
  input wire logic        period_sync_pulse,
  input wire logic        sync_irq,
  input wire logic        shutdown_irq,
  input wire logic        phase_a_high_out,
  input wire logic        phase_a_low_out,
  input wire logic        phase_b_high_out,
  input wire logic        phase_b_low_out,
  input wire logic        phase_c_high_out,
  input wire logic        phase_c_low_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  sequence s_tripped;
    !shutdown_trip_pin_n [*8];
  endsequence

  property p_apb_ready;
    s_setup |=> s_answer;
  endproperty
  property p_ready_only;
    pready |-> penable && $past(psel && !penable);
  endproperty
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_irq_sync;
    sync_irq == period_sync_pulse;
  endproperty
  property p_sync_pulse;
    $rose(period_sync_pulse) |=> !period_sync_pulse;
  endproperty
  property p_trip_off;
    !shutdown_trip_pin_n |-> !(phase_a_high_out || phase_a_low_out || phase_b_high_out ||
                               phase_b_low_out || phase_c_high_out || phase_c_low_out);
  endproperty
  property p_trip_irq;
    $fell(shutdown_trip_pin_n) |-> ##[1:4] shutdown_irq;
  endproperty
  property p_trip_quiet;
    s_tripped |-> !period_sync_pulse;
  endproperty
  property p_pair_excl;
    !(phase_a_high_out && phase_a_low_out) && !(phase_b_high_out && phase_b_low_out) &&
    !(phase_c_high_out && phase_c_low_out);
  endproperty

  a_apb_ready: assert property (p_apb_ready) else $error("no answer after setup");
  a_ready_only: assert property (p_ready_only) else $error("stray ready");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  a_irq_sync: assert property (p_irq_sync) else $error("sync interrupt off the sync pulse");
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse too long");
  a_trip_off: assert property (p_trip_off) else $error("output on while tripped");
  a_trip_irq: assert property (p_trip_irq) else $error("no shutdown interrupt");
  a_trip_quiet: assert property (p_trip_quiet) else $error("sync while tripped");
  a_pair_excl: assert property (p_pair_excl) else $error("both sides of a leg on");
endmodule : tpw_top_properties

bind tpw_top tpw_top_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .shutdown_trip_pin_n(shutdown_trip_pin_n), .ext_sync_in(ext_sync_in),
  .period_sync_pulse(period_sync_pulse), .sync_irq(sync_irq), .shutdown_irq(shutdown_irq),
  .phase_a_high_out(phase_a_high_out), .phase_a_low_out(phase_a_low_out),
  .phase_b_high_out(phase_b_high_out), .phase_b_low_out(phase_b_low_out),
  .phase_c_high_out(phase_c_high_out), .phase_c_low_out(phase_c_low_out)
);

// [three_phase_pwm_timing_tb.sv]
// Self-checking bench for the three-phase PWM block, driven over APB.
// Assumes the design, the checker and the gate driver model are compiled first.
`timescale 1ns/1ps
`include "tpw_map.svh"

module three_phase_pwm_timing_tb;
  logic        pclk, presetn, psel, penable, pwrite, trip_n, ext_sync, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, q;
  wire  [31:0] prdata;
  wire  [5:0]  gate;
  wire         pready, pslverr, sync, sirq, tirq;
  int          n_fail, check_count, shoot, n, hi, lo, per, act;
  int          oes_tab [3] = '{32'h100, 32'h20, 32'h10};
  int          hi_tab [3] = '{4, 0, 6};
  int          lo_tab [3] = '{6, 4, 0};

  tpw_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_trip_pin_n(trip_n), .ext_sync_in(ext_sync), .period_sync_pulse(sync),
    .sync_irq(sirq), .shutdown_irq(tirq), .phase_a_high_out(gate[5]), .phase_a_low_out(gate[4]),
    .phase_b_high_out(gate[3]), .phase_b_low_out(gate[2]), .phase_c_high_out(gate[1]),
    .phase_c_low_out(gate[0])
  );
  tpw_gate_model u_gates (.pclk(pclk), .gate(gate), .shoot_count(shoot));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      k++;
    end
    chk("apb wait states", 32'h0, k);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(name, exp, q);
    chk("slave error", 32'h0, {31'h0, e});
  endtask : rdchk

  task automatic wait_sync();
    n = 0;
    @(posedge pclk);
    while (sync !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_sync

  // Counts phase A on-cycles over one sync-to-sync span.
  task automatic measure();
    wait_sync();
    hi = 0;
    lo = 0;
    per = 0;
    do begin
      @(posedge pclk);
      per++;
      hi += int'(gate[5] === 1'b1);
      lo += int'(gate[4] === 1'b1);
    end while (sync !== 1'b1 && per < 300);
  endtask : measure

  // Counts sync pulses, cycles with any output on, and shutdown interrupts.
  task automatic watch(input int k);
    act = 0;
    hi = 0;
    lo = 0;
    repeat (k) begin
      @(posedge pclk);
      act += int'(sync === 1'b1);
      hi += int'(gate !== 6'h0);
      lo += int'(tirq === 1'b1);
    end
  endtask : watch

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  initial begin
    #2000000;
    n_fail++;
    $display("ERROR watchdog expected finish seen timeout");
    stop_test();
  end

  initial begin
    n_fail = 0;
    check_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    trip_n = 1'b1;
    ext_sync = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rdchk("reset value", 8'(4 * i), (i == 1) ? 32'h2 : 32'h0);
    end
    rd(8'h20);
    chk("unmapped error", 32'h1, {31'h0, e});
    $display("test reset done");
    wr(`TPW_ADDR_HALF, 32'hffffffff);
    rdchk("half width", `TPW_ADDR_HALF, 32'hffff);
    wr(`TPW_ADDR_DEAD, 32'hffffffff);
    rdchk("dead width", `TPW_ADDR_DEAD, 32'h3ff);
    wr(`TPW_ADDR_DUTY_A, 32'h1234abcd);
    rdchk("duty width", `TPW_ADDR_DUTY_A, 32'habcd);
    wr(`TPW_ADDR_HALF, 32'h8);
    wr(`TPW_ADDR_DEAD, 32'h1);
    wr(`TPW_ADDR_DUTY_A, 32'h3);
    wr(`TPW_ADDR_DUTY_B, 32'h8);
    watch(40);
    chk("idle activity", 32'h0, act + hi);
    wr(`TPW_ADDR_DUTY_C, 32'h0);
    measure();
    chk("period", 32'd16, per);
    chk("sync irq", 32'h1, {31'h0, sirq});
    chk("high on", 32'd4, hi);
    chk("low on", 32'd8, lo);
    wait_sync();
    rd(`TPW_ADDR_STATUS);
    chk("first half", 32'h0, {31'h0, q[0]});
    repeat (7) @(posedge pclk);
    rd(`TPW_ADDR_STATUS);
    chk("second half", 32'h1, {31'h0, q[0]});
    $display("test timing done");
    wr(`TPW_ADDR_HALF, 32'h5);
    measure();
    chk("shadow period", 32'd10, per);
    chk("shadow high", 32'd4, hi);
    chk("shadow low", 32'd2, lo);
    wr(`TPW_ADDR_DEAD, 32'h0);
    measure();
    chk("zero dead high", 32'd6, hi);
    chk("zero dead low", 32'd4, lo);
    for (int i = 0; i < 3; i++) begin
      wr(`TPW_ADDR_OES, oes_tab[i]);
      measure();
      chk("steer high", hi_tab[i], hi);
      chk("steer low", lo_tab[i], lo);
    end
    wr(`TPW_ADDR_OES, 32'h0);
    $display("test shape done");
    wr(`TPW_ADDR_CONTROL, 32'h110);
    measure();
    chk("chop high cut", 32'h1, {31'h0, hi < 6});
    chk("chop low kept", 32'd4, lo);
    wr(`TPW_ADDR_CONTROL, 32'h4);
    measure();
    measure();
    chk("double spacing", 32'd5, per);
    chk("double high", 32'd3, hi);
    wr(`TPW_ADDR_CONTROL, 32'h8);
    repeat (20) @(posedge pclk);
    watch(30);
    chk("external hold", 32'h0, act);
    ext_sync <= 1'b1;
    wait_sync();
    chk("external start", 32'h1, {31'h0, n < 10});
    ext_sync <= 1'b0;
    wr(`TPW_ADDR_CONTROL, 32'h0);
    $display("test modes done");
    trip_n <= 1'b0;
    #1;
    chk("trip outputs", 32'h0, {26'h0, gate});
    watch(30);
    chk("trip irq", 32'h1, lo);
    rd(`TPW_ADDR_STATUS);
    chk("trip status", 32'h0, {31'h0, q[1]});
    trip_n <= 1'b1;
    wait_sync();
    chk("restart", 32'h1, {31'h0, n < 50});
    chk("shoot through", 32'h0, shoot);
    $display("test trip done");
    stop_test();
  end
endmodule : three_phase_pwm_timing_tb
